/* File: ouc_apb.sv */
`timescale 1ns/1ps
`default_nettype none
// APB slave holding settings, relay assignment and interrupt registers.
module ouc_apb
   import ouc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Settings to the protection core.
   output logic [9:0] oc_lvl,
   output logic [9:0] oc_dly,
   output logic [9:0] uc_lvl,
   output logic [9:0] uc_dly,
   output logic oc_relay_en,
   output logic uc_relay_en,
   output logic fault_clr,
   // State from the protection core.
   input wire logic [IRQ_W-1:0] events,
   input wire logic [IRQ_W-1:0] live,
   input wire logic [7:0] fault_code,
   output logic irq
);
   // Whole register state.
   typedef struct packed
   {
      logic [9:0] oc_lvl;
      logic [9:0] oc_dly;
      logic [9:0] uc_lvl;
      logic [9:0] uc_dly;
      logic [1:0] relay;
      logic clr;
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] mask;
      logic [31:0] rdata;
      logic err;
      logic rdy;
   } ouc_regs_t;
   ouc_regs_t s_reg;
   ouc_regs_t s_next;
   // First access cycle, in which the answer is prepared.
   logic pre;
   logic acc;
   logic bad_wr;

   // Decode, write, read and sticky status.
   always_comb
   begin
      s_next = s_reg;
      s_next.clr = 1'b0;
      // The answer is registered in the first access cycle; the second completes.
      pre = psel && penable && !s_reg.rdy;
      acc = psel && penable && s_reg.rdy;
      bad_wr = 1'b0;
      if (psel && penable && pwrite)
      begin
         if (paddr == ADDR_CTRL)
         begin
            s_next.relay = pwdata[1:0];
            s_next.clr = pwdata[CTRL_FAULT_CLR];
         end
         else if (paddr == ADDR_OC_LVL)
         begin
            // Out-of-range levels are refused.
            if (pwdata[31:10] == '0 && (pwdata[9:0] == 10'h000
                || (pwdata[9:0] >= OC_LVL_MIN && pwdata[9:0] <= OC_LVL_MAX)))
               s_next.oc_lvl = pwdata[9:0];
            else
               bad_wr = 1'b1;
         end
         else if (paddr == ADDR_OC_DLY)
         begin
            if (pwdata[31:10] == '0 && pwdata[9:0] <= DLY_MAX)
               s_next.oc_dly = pwdata[9:0];
            else
               bad_wr = 1'b1;
         end
         else if (paddr == ADDR_UC_LVL)
         begin
            if (pwdata[31:10] == '0 && (pwdata[9:0] == 10'h000
                || (pwdata[9:0] >= UC_LVL_MIN && pwdata[9:0] <= UC_LVL_MAX)))
               s_next.uc_lvl = pwdata[9:0];
            else
               bad_wr = 1'b1;
         end
         else if (paddr == ADDR_UC_DLY)
         begin
            if (pwdata[31:10] == '0 && pwdata[9:0] <= DLY_MAX)
               s_next.uc_dly = pwdata[9:0];
            else
               bad_wr = 1'b1;
         end
         else if (paddr == ADDR_IRQ_STAT)
         begin
            s_next.stat = s_reg.stat & ~pwdata[IRQ_W-1:0];
         end
         else if (paddr == ADDR_IRQ_MASK)
         begin
            s_next.mask = pwdata[IRQ_W-1:0];
         end
         else if (paddr != ADDR_STATUS)
         begin
            bad_wr = 1'b1;
         end
      end
      // Settings and clears take effect only at the completing edge.
      if (!acc)
      begin
         s_next = s_reg;
         s_next.clr = 1'b0;
      end
      // The wait state lets the registered answer stand while pready is high.
      s_next.rdy = pre;
      // New events win over a clear in the same cycle.
      s_next.stat = s_next.stat | events;
      s_next.err = pre && bad_wr;
      s_next.rdata = '0;
      if (pre && !pwrite)
      begin
         if (paddr == ADDR_CTRL)
            s_next.rdata = {30'h0, s_reg.relay};
         else if (paddr == ADDR_OC_LVL)
            s_next.rdata = {22'h0, s_reg.oc_lvl};
         else if (paddr == ADDR_OC_DLY)
            s_next.rdata = {22'h0, s_reg.oc_dly};
         else if (paddr == ADDR_UC_LVL)
            s_next.rdata = {22'h0, s_reg.uc_lvl};
         else if (paddr == ADDR_UC_DLY)
            s_next.rdata = {22'h0, s_reg.uc_dly};
         else if (paddr == ADDR_STATUS)
            s_next.rdata = {20'h0, fault_code, live};
         else if (paddr == ADDR_IRQ_STAT)
            s_next.rdata = {28'h0, s_reg.stat};
         else if (paddr == ADDR_IRQ_MASK)
            s_next.rdata = {28'h0, s_reg.mask};
         else
            s_next.err = 1'b1;
      end
   end

   // Register state; settings reset to off levels and minimum delays.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
         s_reg.oc_lvl <= LVL_RST;
         s_reg.uc_lvl <= LVL_RST;
         s_reg.oc_dly <= DLY_RST;
         s_reg.uc_dly <= DLY_RST;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   // One wait state: pready rises in the second access cycle.
   assign pready = s_reg.rdy;
   assign prdata = s_reg.rdata;
   assign pslverr = s_reg.err;
   assign oc_lvl = s_reg.oc_lvl;
   assign oc_dly = s_reg.oc_dly;
   assign uc_lvl = s_reg.uc_lvl;
   assign uc_dly = s_reg.uc_dly;
   assign oc_relay_en = s_reg.relay[CTRL_OC_RELAY];
   assign uc_relay_en = s_reg.relay[CTRL_UC_RELAY];
   assign fault_clr = s_reg.clr;
   assign irq = |(s_reg.stat & s_reg.mask);
endmodule // ouc_apb
`default_nettype wire

/* File: ouc_delay.sv */
`timescale 1ns/1ps
`default_nettype none
// Persistence timer: counts tenth-second ticks while the condition holds.
module ouc_delay
   import ouc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // Timing base and condition.
   input wire logic tick,
   input wire logic cond,
   input wire logic [9:0] delay,
   // Expiry level.
   output logic expired
);
   // Whole state of the timer.
   typedef struct packed
   {
      logic [9:0] count;
      logic done;
   } ouc_dly_t;
   ouc_dly_t s_reg;
   ouc_dly_t s_next;

   // Next state: counting, clearing and expiry.
   always_comb
   begin
      s_next = s_reg;
      if (!cond || delay == 10'h000)
      begin
         // Condition gone or delay off clears the timer.
         s_next.count = 10'h000;
         s_next.done = 1'b0;
      end
      else if (tick && !s_reg.done)
      begin
         // One more tenth of a second of persistence.
         s_next.count = s_reg.count + 10'h001;
         if (s_reg.count + 10'h001 >= delay)
         begin
            s_next.done = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   assign expired = s_reg.done;
endmodule // ouc_delay
`default_nettype wire

/* File: ouc_meas_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Measurement front end: one averaged result per line cycle.
module ouc_meas_model
   import ouc_pkg::*;
#(
   parameter int PERIOD = 16
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Current the motor draws, set by the bench.
   input wire logic [CUR_W-1:0] level,
   // Result toward the block.
   output logic [CUR_W-1:0] cycle_current,
   output logic cycle_valid
);
   // Counts clocks of one line cycle.
   int cnt;
   // Between results the data lines carry a scrambled value, so stale reads show.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 0;
         cycle_valid <= 1'b0;
         cycle_current <= '0;
      end
      else if (cnt == PERIOD - 1)
      begin
         cnt <= 0;
         cycle_valid <= 1'b1;
         cycle_current <= level;
      end
      else
      begin
         cnt <= cnt + 1;
         cycle_valid <= 1'b0;
         cycle_current <= ~level;
      end
   end
endmodule // ouc_meas_model
`default_nettype wire

/* File: ouc_pkg.sv */
// Overview of operation
// - Over-current level: off or 50 to 800 percent.
// - Current above level raises over-current alarm, relay.
// - Over-current persisting past delay trips, drops fault relay.
// - Over-current trip armed only in permitted run states.
// - Relay may follow over-current alarm condition.
// - Over-current delay off or 0.1 to 90.0 seconds.
// - Delay off: no trip, relay held while over.
// - Under-current level: off or 5 to 100 percent.
// - Current below level raises under-current alarm, relay.
// - Under-current persisting past delay trips, drops fault relay.
// - Under-current trip armed only in permitted run states.
// - Relay may follow under-current alarm condition.
// - Under-current delay off or 0.1 to 90.0 seconds.
// - Delay off: no trip, relay held while under.
package ouc_pkg;
   // System clock rate in hertz.
   localparam int unsigned CLK_HZ = 10_000_000;
   // Delay settings are in tenths of a second; one tick lasts 100 ms.
   localparam int unsigned TICK_MS = 100;
   // Clock cycles per tenth-second tick, derived from the rate.
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // Level setting: percent of full load current, zero means off.
   localparam logic [9:0] OC_LVL_MIN = 10'h032;
   localparam logic [9:0] OC_LVL_MAX = 10'h320;
   localparam logic [9:0] UC_LVL_MIN = 10'h005;
   localparam logic [9:0] UC_LVL_MAX = 10'h064;
   // Delay setting in tenths of a second, zero means off.
   localparam logic [9:0] DLY_MIN = 10'h001;
   localparam logic [9:0] DLY_MAX = 10'h384;
   // Reset values of settings.
   localparam logic [9:0] LVL_RST = 10'h000;
   localparam logic [9:0] DLY_RST = 10'h001;
   // Fault codes reported on trip.
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [7:0] OVERCURRENT_TRIP_CODE = 8'h1F;
   localparam logic [7:0] UNDERCURRENT_TRIP_CODE = 8'h22;
   // APB register byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OC_LVL = 8'h04;
   localparam logic [7:0] ADDR_OC_DLY = 8'h08;
   localparam logic [7:0] ADDR_UC_LVL = 8'h0C;
   localparam logic [7:0] ADDR_UC_DLY = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
   // Control register bits.
   localparam int CTRL_OC_RELAY = 0;
   localparam int CTRL_UC_RELAY = 1;
   localparam int CTRL_FAULT_CLR = 2;
   // Interrupt status bits.
   localparam int IRQ_OC_ALARM = 0;
   localparam int IRQ_UC_ALARM = 1;
   localparam int IRQ_OC_TRIP = 2;
   localparam int IRQ_UC_TRIP = 3;
   localparam int IRQ_W = 4;
   // Width of the current measurement in percent of full load.
   localparam int CUR_W = 12;
   // Motor run states the measurement side reports.
   typedef enum logic [2:0]
   {
      OUC_ST_STOPPED,
      OUC_ST_STARTING,
      OUC_ST_UP_TO_SPEED,
      OUC_ST_ENERGY_SAVER,
      OUC_ST_CUR_FOLLOWER,
      OUC_ST_PHASE_CTRL,
      OUC_ST_STOPPING
   } ouc_run_t;
endpackage

/* File: ouc_prot.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Over- and under-current protection with alarms, relays and trips.
module ouc_prot
   import ouc_pkg::*;
#(
   // Clock cycles per tenth-second delay tick.
   parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
   // Clock, reset and clock enable.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurement front end, same clock domain.
   input wire logic [CUR_W-1:0] cycle_current,
   input wire logic cycle_valid,
   input wire logic [2:0] run_state,
   // Relays and indication.
   output logic oc_alarm,
   output logic uc_alarm,
   output logic oc_relay,
   output logic uc_relay,
   output logic fault_relay,
   output logic [7:0] fault_code,
   output logic irq
);
   // Whole state of the core.
   typedef struct packed
   {
      logic [23:0] tick_cnt;
      logic tick;
      logic oc;
      logic uc;
      logic tripped;
      logic [7:0] code;
      logic [IRQ_W-1:0] ev;
   } ouc_core_t;
   ouc_core_t s_reg;
   ouc_core_t s_next;
   logic [9:0] oc_lvl;
   logic [9:0] oc_dly;
   logic [9:0] uc_lvl;
   logic [9:0] uc_dly;
   logic oc_relay_en;
   logic uc_relay_en;
   logic fault_clr;
   logic oc_exp;
   logic uc_exp;
   logic armed;
   logic [IRQ_W-1:0] live;

   // Register block.
   ouc_apb u_apb
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .oc_lvl(oc_lvl),
      .oc_dly(oc_dly),
      .uc_lvl(uc_lvl),
      .uc_dly(uc_dly),
      .oc_relay_en(oc_relay_en),
      .uc_relay_en(uc_relay_en),
      .fault_clr(fault_clr),
      .events(s_reg.ev),
      .live(live),
      .fault_code(s_reg.code),
      .irq(irq)
   );

   // Over-current persistence timer.
   ouc_delay u_oc_dly
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .tick(s_reg.tick),
      .cond(s_reg.oc),
      .delay(oc_dly),
      .expired(oc_exp)
   );

   // Under-current persistence timer.
   ouc_delay u_uc_dly
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .tick(s_reg.tick),
      .cond(s_reg.uc),
      .delay(uc_dly),
      .expired(uc_exp)
   );

   // Trips are armed only in the steady run states.
   always_comb
   begin
      case (ouc_run_t'(run_state))
         OUC_ST_UP_TO_SPEED: armed = 1'b1;
         OUC_ST_ENERGY_SAVER: armed = 1'b1;
         OUC_ST_CUR_FOLLOWER: armed = 1'b1;
         OUC_ST_PHASE_CTRL: armed = 1'b1;
         default: armed = 1'b0;
      endcase
   end

   // Tick generation, level compare per cycle and trip latch.
   always_comb
   begin
      s_next = s_reg;
      s_next.ev = '0;
      // A tenth-second tick from the system clock.
      if (s_reg.tick_cnt == 24'(TICK_DIV - 1))
      begin
         s_next.tick_cnt = '0;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.tick_cnt = s_reg.tick_cnt + 24'h000001;
         s_next.tick = 1'b0;
      end
      // Each cycle's average is compared; an off level raises nothing.
      if (cycle_valid)
      begin
         s_next.oc = (oc_lvl != 10'h000) && (cycle_current > {2'b00, oc_lvl});
         s_next.uc = (uc_lvl != 10'h000) && (cycle_current < {2'b00, uc_lvl});
      end
      if (oc_lvl == 10'h000)
         s_next.oc = 1'b0;
      if (uc_lvl == 10'h000)
         s_next.uc = 1'b0;
      // Alarm onsets are reported as events.
      s_next.ev[IRQ_OC_ALARM] = s_next.oc && !s_reg.oc;
      s_next.ev[IRQ_UC_ALARM] = s_next.uc && !s_reg.uc;
      // First trip latches until software clears it; a new trip wins over a clear.
      if (!s_reg.tripped && armed && oc_exp && s_reg.oc)
      begin
         s_next.tripped = 1'b1;
         s_next.code = OVERCURRENT_TRIP_CODE;
         s_next.ev[IRQ_OC_TRIP] = 1'b1;
      end
      else if (!s_reg.tripped && armed && uc_exp && s_reg.uc)
      begin
         s_next.tripped = 1'b1;
         s_next.code = UNDERCURRENT_TRIP_CODE;
         s_next.ev[IRQ_UC_TRIP] = 1'b1;
      end
      else if (fault_clr)
      begin
         s_next.tripped = 1'b0;
         s_next.code = FAULT_NONE;
      end
   end

   // Core state register.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   assign live = {s_reg.tripped && s_reg.code == UNDERCURRENT_TRIP_CODE,
                  s_reg.tripped && s_reg.code == OVERCURRENT_TRIP_CODE,
                  s_reg.uc, s_reg.oc};
   assign oc_alarm = s_reg.oc;
   assign uc_alarm = s_reg.uc;
   // Assigned relays follow the alarm, held while the delay is off.
   assign oc_relay = oc_relay_en && s_reg.oc;
   assign uc_relay = uc_relay_en && s_reg.uc;
   // Fault relay is energized while healthy and drops on a trip.
   assign fault_relay = !s_reg.tripped;
   assign fault_code = s_reg.code;
endmodule // ouc_prot
`default_nettype wire

/* File: ouc_prot_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the protection block at its ports and flags broken timing or values.
module ouc_prot_properties
   import ouc_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Measurement strobe and run state.
   input wire logic cycle_valid,
   input wire logic [2:0] run_state,
   // Alarms, relays and fault indication.
   input wire logic oc_alarm,
   input wire logic uc_alarm,
   input wire logic oc_relay,
   input wire logic uc_relay,
   input wire logic fault_relay,
   input wire logic [7:0] fault_code
);
   // True at the edge that completes a register write.
   logic wr;
   assign wr = psel && penable && pwrite && pready && ce;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   AST_OC_LVL_RANGE: assert property (
      wr && paddr == ADDR_OC_LVL && (pwdata > 32'h320 || (pwdata != 0 && pwdata < 32'h32))
      |-> pslverr) else $error("over-current level out of range was accepted");
   AST_UC_LVL_RANGE: assert property (
      wr && paddr == ADDR_UC_LVL && (pwdata > 32'h64 || (pwdata != 0 && pwdata < 32'h5))
      |-> pslverr) else $error("under-current level out of range was accepted");
   AST_DLY_RANGE: assert property (
      wr && (paddr == ADDR_OC_DLY || paddr == ADDR_UC_DLY) && pwdata > 32'h384
      |-> pslverr) else $error("delay out of range was accepted");
   AST_OC_ALARM_SRC: assert property (
      $changed(oc_alarm) |-> $past(cycle_valid)) else $error("over alarm moved without a sample");
   AST_UC_ALARM_SRC: assert property (
      $changed(uc_alarm) |-> $past(cycle_valid)) else $error("under alarm moved without a sample");
   AST_OC_RELAY: assert property (
      oc_relay |-> oc_alarm) else $error("over relay energized without alarm");
   AST_UC_RELAY: assert property (
      uc_relay |-> uc_alarm) else $error("under relay energized without alarm");
   AST_OC_ARMED: assert property (
      $rose(fault_code == OVERCURRENT_TRIP_CODE) |-> $past(run_state) inside {[3'h2:3'h5]})
      else $error("over-current trip in an unarmed state");
   AST_UC_ARMED: assert property (
      $rose(fault_code == UNDERCURRENT_TRIP_CODE) |-> $past(run_state) inside {[3'h2:3'h5]})
      else $error("under-current trip in an unarmed state");
   AST_TRIP_DROPS_FAULT: assert property (
      fault_code != FAULT_NONE |-> !fault_relay) else $error("fault relay held during a trip");
   // Main scenarios seen.
   COV_OC: cover property ($rose(oc_alarm));
   COV_UC: cover property ($rose(uc_alarm));
   COV_ERR: cover property (pslverr);
endmodule // ouc_prot_properties
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the protection block.
module tb_top
   import ouc_pkg::*;
;
   // Clock, reset, enable and bus.
   logic clk_sys, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, fault_code;
   logic [31:0] pwdata, prdata, rd;
   // Measurement side and outputs.
   logic [CUR_W-1:0] cycle_current, meas_level;
   logic cycle_valid, oc_alarm, uc_alarm, oc_relay, uc_relay, fault_relay, irq;
   logic [2:0] run_state;
   // Result counters.
   int mismatches, check_count;
   // Block under test and its measurement partner.
   // A short tick keeps the trip scenarios within the run.
   ouc_prot #(.TICK_DIV(40)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cycle_current(cycle_current),
      .cycle_valid(cycle_valid), .run_state(run_state), .oc_alarm(oc_alarm),
      .uc_alarm(uc_alarm), .oc_relay(oc_relay), .uc_relay(uc_relay),
      .fault_relay(fault_relay), .fault_code(fault_code), .irq(irq));
   ouc_meas_model meas_u (.clk_sys(clk_sys), .nrst(nrst), .level(meas_level),
      .cycle_current(cycle_current), .cycle_valid(cycle_valid));
   // Compares one bit.
   task automatic chk_bit(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
         mismatches++;
      end
   endtask
   // Compares one word.
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   // One bus transfer; read data and error are taken at the completing edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      // Answer and pready are read at the same edge, before it updates them.
      do
      begin
         @(posedge clk_sys);
         rd = prdata;
         er = pslverr;
      end
      while (pready !== 1'b1 && n++ < 50);
      if (n >= 50)
         mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Waits for two measurement results to land in the alarms.
   task automatic settle(input logic [CUR_W-1:0] lvl);
      int n;
      @(posedge clk_sys);
      meas_level <= lvl;
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         do @(posedge clk_sys); while (cycle_valid !== 1'b1 && n++ < 100);
      end
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Reset values of the settings and outputs.
   task automatic test_reset();
      logic [7:0] a [4] = '{ADDR_OC_LVL, ADDR_OC_DLY, ADDR_UC_LVL, ADDR_UC_DLY};
      logic [31:0] e [4] = '{32'h0, 32'h1, 32'h0, 32'h1};
      chk_bit("fault_relay", 1'b1, fault_relay);
      chk_word("fault_code", FAULT_NONE, fault_code);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, a[i], 32'h0);
         chk_word("setting", e[i], rd);
      end
      $display("test reset done");
   endtask
   // Levels beyond both bounds and at one, delays beyond the maximum and at it or off, plus an unmapped place.
   task automatic test_limits();
      logic [7:0] a [10] = '{ADDR_OC_LVL, ADDR_OC_LVL, ADDR_OC_LVL, ADDR_UC_LVL, ADDR_UC_LVL,
         ADDR_UC_LVL, ADDR_OC_DLY, ADDR_OC_DLY, ADDR_UC_DLY, ADDR_UC_DLY};
      logic [31:0] d [10] = '{32'h321, 32'h31, 32'h320, 32'h65, 32'h4, 32'h5,
         32'h385, 32'h384, 32'h385, 32'h0};
      logic [31:0] b [10] = '{32'h0, 32'h0, 32'h320, 32'h0, 32'h0, 32'h5,
         32'h1, 32'h384, 32'h1, 32'h0};
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b1, a[i], d[i]);
         chk_bit("refused", b[i] !== d[i], er);
         apb(1'b0, a[i], 32'h0);
         chk_word("readback", b[i], rd);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk_bit("unmapped_err", 1'b1, er);
      chk_word("unmapped_data", 32'h0, rd);
      $display("test limits done");
   endtask
   // Over-current alarm, relay, interrupt and withdrawal.
   task automatic test_over();
      apb(1'b1, ADDR_OC_LVL, 32'h64);
      apb(1'b1, ADDR_OC_DLY, 32'h0);
      apb(1'b1, ADDR_UC_LVL, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_IRQ_MASK, 32'hF);
      apb(1'b1, ADDR_IRQ_STAT, 32'hF);
      settle(12'h064);
      chk_bit("oc_alarm_equal", 1'b0, oc_alarm);
      settle(12'h065);
      chk_bit("oc_alarm", 1'b1, oc_alarm);
      chk_bit("oc_relay", 1'b1, oc_relay);
      chk_bit("irq_on", 1'b1, irq);
      settle(12'h065);
      chk_bit("oc_relay_held", 1'b1, oc_relay);
      chk_bit("no_trip", 1'b1, fault_relay);
      settle(12'h050);
      chk_bit("oc_alarm_off", 1'b0, oc_alarm);
      chk_bit("oc_relay_off", 1'b0, oc_relay);
      apb(1'b1, ADDR_IRQ_STAT, 32'hF);
      @(posedge clk_sys);
      #1;
      chk_bit("irq_clear", 1'b0, irq);
      apb(1'b1, ADDR_CTRL, 32'h0);
      settle(12'h0C8);
      chk_bit("oc_unassigned", 1'b0, oc_relay);
      $display("test over done");
   endtask
   // Under-current alarm with the interrupt masked, then unmasked.
   task automatic test_under();
      apb(1'b1, ADDR_UC_LVL, 32'h14);
      apb(1'b1, ADDR_UC_DLY, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, ADDR_IRQ_STAT, 32'hF);
      settle(12'h014);
      apb(1'b1, ADDR_OC_LVL, 32'h0);
      chk_bit("uc_alarm_equal", 1'b0, uc_alarm);
      settle(12'h013);
      chk_bit("uc_alarm", 1'b1, uc_alarm);
      chk_bit("uc_relay", 1'b1, uc_relay);
      chk_bit("irq_masked", 1'b0, irq);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk_word("status", 32'h2, rd & 32'hF);
      apb(1'b1, ADDR_IRQ_MASK, 32'h2);
      @(posedge clk_sys);
      #1;
      chk_bit("irq_unmasked", 1'b1, irq);
      settle(12'h032);
      chk_bit("uc_alarm_off", 1'b0, uc_alarm);
      chk_bit("uc_relay_off", 1'b0, uc_relay);
      chk_bit("no_trip", 1'b1, fault_relay);
      $display("test under done");
   endtask
   // Early clearing, unarmed hold, over trip, fault clear and under trip.
   task automatic test_trip();
      apb(1'b1, ADDR_UC_LVL, 32'h0);
      apb(1'b1, ADDR_OC_LVL, 32'h64);
      apb(1'b1, ADDR_OC_DLY, 32'h3);
      settle(12'h0C8);
      settle(12'h050);
      chk_bit("early_clear", 1'b1, fault_relay);
      @(posedge clk_sys);
      run_state <= OUC_ST_STARTING;
      settle(12'h0C8);
      repeat (200) @(posedge clk_sys);
      chk_bit("unarmed", 1'b1, fault_relay);
      run_state <= OUC_ST_UP_TO_SPEED;
      repeat (3) @(posedge clk_sys);
      #1;
      chk_word("oc_trip", OVERCURRENT_TRIP_CODE, fault_code);
      chk_bit("oc_trip_relay", 1'b0, fault_relay);
      settle(12'h050);
      apb(1'b1, ADDR_CTRL, 32'h4);
      repeat (2) @(posedge clk_sys);
      #1;
      chk_word("trip_clear", FAULT_NONE, fault_code);
      apb(1'b1, ADDR_OC_LVL, 32'h0);
      apb(1'b1, ADDR_UC_LVL, 32'h14);
      apb(1'b1, ADDR_UC_DLY, 32'h1);
      settle(12'h00A);
      repeat (100) @(posedge clk_sys);
      #1;
      chk_word("uc_trip", UNDERCURRENT_TRIP_CODE, fault_code);
      chk_bit("uc_trip_relay", 1'b0, fault_relay);
      $display("test trip done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Free-running 10 MHz clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Cuts a hang short well beyond the expected run.
   initial
   begin
      repeat (50000) @(posedge clk_sys);
      mismatches++;
      results();
   end
   // Main sequence.
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      meas_level = 12'h064;
      run_state = OUC_ST_UP_TO_SPEED;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      test_reset();
      test_limits();
      test_over();
      test_under();
      test_trip();
      results();
   end
endmodule // tb_top
bind ouc_prot ouc_prot_properties chk_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .cycle_valid(cycle_valid), .run_state(run_state), .oc_alarm(oc_alarm),
   .uc_alarm(uc_alarm), .oc_relay(oc_relay), .uc_relay(uc_relay), .fault_relay(fault_relay),
   .fault_code(fault_code));
`default_nettype wire
